// File: rtl/tpt_trigger.sv
`timescale 1ns/1ps
// Functional notes
// - transmission type 0xfe sends the pdo each time the event timer ends.
// - the event timer is a 16-bit millisecond period at 1800/05.
// - an event timer of zero stops timer-based sending.
// - types 1..240 send the pdo once per n sync messages, n being the type.
// - the transmission type sits at 1800/02, written by expedited download.
// - type 0xff sends only on limit events, never on sync or timer.
// - lower and upper float32 limits sit at 6134/01 and 6135/01, le order.
// - in event mode the pdo is sent each time the value leaves the range.
// - a new event needs the value back inside the range by 1 percent.
// - each good write gets 0x580+node, dlc 8, 0x60, index, sub, zeros.
// - "save" at 1010/01 stores the set to nvm and is acknowledged.
// - "load" at 1011/01 restores factory type, timer and limits and is acknowledged.
module tpt_trigger
  import tpt_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [10:0] rx_id,
  input wire logic [3:0] rx_dlc,
  input wire logic [63:0] rx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [10:0] tx_id,
  output logic [3:0] tx_dlc,
  output logic [63:0] tx_data,
  input wire logic sync_pulse,
  input wire logic ms_tick,
  input wire logic pv_valid,
  input wire logic [31:0] pv_value,
  output logic tpdo_send,
  output logic nvm_save,
  output logic nvm_restore,
  output logic irq
);

  function automatic logic [31:0] tpt_key(input logic [31:0] f);
    tpt_key = f[31] ? ~f : {1'b1, f[30:0]};
  endfunction : tpt_key

  // moves a float magnitude up or down by 1 percent
  function automatic logic [31:0] tpt_bump(input logic [31:0] f,
                                           input logic grow);
    logic [47:0] p;
    logic [24:0] s;
    p = {1'b1, f[22:0]} * PCT_MUL;
    if (f[30:23] == 8'h00)
      tpt_bump = f;
    else if (grow)
    begin
      s = {2'b01, f[22:0]} + {7'h00, p[47:30]};
      tpt_bump = s[24] ? {f[31], f[30:23] + 8'h01, s[23:1]}
                       : {f[31], f[30:23], s[22:0]};
    end
    else
    begin
      s = {2'b01, f[22:0]} - {7'h00, p[47:30]};
      tpt_bump = s[23] ? {f[31], f[30:23], s[22:0]}
                       : {f[31], f[30:23] - 8'h01, s[21:0], 1'b0};
    end
  endfunction : tpt_bump

  //////////////////////////////////////////////////////////////////////////
  // sdo decode
  logic [7:0] ttype_reg, ttype_next;
  logic [15:0] etimer_reg, etimer_next;
  logic [31:0] lo_reg, lo_next, hi_reg, hi_next;
  logic [6:0] node_reg, node_next;
  logic [15:0] idx;
  logic [7:0] sub;
  logic [31:0] wdat;
  logic sdo_hit, wr_tt, wr_et, wr_lo, wr_hi, wr_save, wr_load, wr_ok;
  assign idx = rx_data[23:8];
  assign sub = rx_data[31:24];
  assign wdat = rx_data[63:32];
  assign rx_ready = !tx_valid;
  assign sdo_hit = rx_valid && rx_ready && rx_dlc == SDO_DLC
    && rx_id == SDO_RX_BASE + {4'h0, node_reg}
    && rx_data[7:0] == CMD_DL4;
  assign wr_tt = sdo_hit && idx == IDX_TPDO1 && sub == SUB_TTYPE;
  assign wr_et = sdo_hit && idx == IDX_TPDO1 && sub == SUB_ETIMER;
  assign wr_lo = sdo_hit && idx == IDX_LIM_LO && sub == SUB_ONE;
  assign wr_hi = sdo_hit && idx == IDX_LIM_HI && sub == SUB_ONE;
  assign wr_save = sdo_hit && idx == IDX_SAVE && sub == SUB_ONE
    && wdat == SIG_SAVE;
  assign wr_load = sdo_hit && idx == IDX_LOAD && sub == SUB_ONE
    && wdat == SIG_LOAD;
  assign wr_ok = wr_tt | wr_et | wr_lo | wr_hi | wr_save | wr_load;
  always_comb
  begin
    ttype_next = ttype_reg;
    etimer_next = etimer_reg;
    lo_next = lo_reg;
    hi_next = hi_reg;
    if (wr_load)
    begin
      ttype_next = TTYPE_FACT;
      etimer_next = ETIMER_FACT;
      lo_next = LIM_LO_FACT;
      hi_next = LIM_HI_FACT;
    end
    if (wr_tt)
      ttype_next = wdat[7:0];
    if (wr_et)
      etimer_next = wdat[15:0];
    if (wr_lo)
      lo_next = wdat;
    if (wr_hi)
      hi_next = wdat;
  end
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      ttype_reg <= TTYPE_FACT;
      etimer_reg <= ETIMER_FACT;
      lo_reg <= LIM_LO_FACT;
      hi_reg <= LIM_HI_FACT;
    end
    else
    begin
      ttype_reg <= ttype_next;
      etimer_reg <= etimer_next;
      lo_reg <= lo_next;
      hi_reg <= hi_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // acknowledge frame
  logic tx_valid_reg, tx_valid_next;
  logic [63:0] tx_data_reg, tx_data_next;
  logic save_reg, save_next, load_reg, load_next;
  always_comb
  begin
    tx_valid_next = tx_valid_reg && !tx_ready;
    tx_data_next = tx_data_reg;
    save_next = wr_save;
    load_next = wr_load;
    if (wr_ok)
    begin
      tx_valid_next = 1'b1;
      tx_data_next = {32'h0, sub, idx, CMD_ACK};
    end
  end
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      tx_valid_reg <= 1'b0;
      tx_data_reg <= 64'h0;
      save_reg <= 1'b0;
      load_reg <= 1'b0;
    end
    else
    begin
      tx_valid_reg <= tx_valid_next;
      tx_data_reg <= tx_data_next;
      save_reg <= save_next;
      load_reg <= load_next;
    end
  end

  assign tx_valid = tx_valid_reg;
  assign tx_data = tx_data_reg;
  assign tx_id = SDO_TX_BASE + {4'h0, node_reg};
  assign tx_dlc = SDO_DLC;
  assign nvm_save = save_reg;
  assign nvm_restore = load_reg;

  //////////////////////////////////////////////////////////////////////////
  // triggers
  logic [15:0] ms_cnt_reg, ms_cnt_next;
  logic [7:0] sync_cnt_reg, sync_cnt_next;
  logic armed_reg, armed_next, send_reg, send_next;
  logic mode_sync, fire_tmr, fire_sync, fire_evt, out_rng, in_band;
  logic [31:0] key_pv;
  assign mode_sync = ttype_reg >= TT_SYNC_MIN && ttype_reg <= TT_SYNC_MAX;
  assign fire_tmr = ttype_reg == TT_TIMER && etimer_reg != 16'h0
    && ms_tick && ms_cnt_reg + 16'h1 >= etimer_reg;
  assign fire_sync = mode_sync && sync_pulse
    && sync_cnt_reg + 8'h1 >= ttype_reg;
  assign key_pv = tpt_key(pv_value);
  assign out_rng = key_pv < tpt_key(lo_reg) || key_pv > tpt_key(hi_reg);
  assign in_band = key_pv > tpt_key(tpt_bump(lo_reg, !lo_reg[31]))
    && key_pv < tpt_key(tpt_bump(hi_reg, hi_reg[31]));
  assign fire_evt = ttype_reg == TT_EVENT && pv_valid && armed_reg
    && out_rng;
  always_comb
  begin
    ms_cnt_next = ms_cnt_reg;
    sync_cnt_next = sync_cnt_reg;
    armed_next = armed_reg;
    send_next = fire_tmr | fire_sync | fire_evt;
    if (wr_et || wr_tt || wr_load || ttype_reg != TT_TIMER)
      ms_cnt_next = 16'h0;
    else if (ms_tick)
      ms_cnt_next = fire_tmr ? 16'h0 : ms_cnt_reg + 16'h1;
    if (wr_tt || wr_load || !mode_sync)
      sync_cnt_next = 8'h0;
    else if (sync_pulse)
      sync_cnt_next = fire_sync ? 8'h0 : sync_cnt_reg + 8'h1;
    if (fire_evt)
      armed_next = 1'b0;
    else if (pv_valid && in_band)
      armed_next = 1'b1;
  end
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      ms_cnt_reg <= 16'h0;
      sync_cnt_reg <= 8'h0;
      armed_reg <= 1'b0;
      send_reg <= 1'b0;
    end
    else
    begin
      ms_cnt_reg <= ms_cnt_next;
      sync_cnt_reg <= sync_cnt_next;
      armed_reg <= armed_next;
      send_reg <= send_next;
    end
  end

  assign tpdo_send = send_reg;

  //////////////////////////////////////////////////////////////////////////
  // apb slave and interrupt
  logic [EV_W-1:0] status_reg, status_next, enable_reg, enable_next;
  logic [EV_W-1:0] ev;
  logic [31:0] prdata_reg, prdata_next;
  logic wr_acc, map_hit;
  assign ev = {fire_evt, wr_load, wr_save, wr_ok, send_next};
  assign wr_acc = psel && penable && pwrite;
  assign map_hit = paddr <= OFS_ARMED && paddr[1:0] == 2'b00;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !map_hit;
  always_comb
  begin
    status_next = status_reg | ev;
    enable_next = enable_reg;
    node_next = node_reg;
    prdata_next = prdata_reg;
    if (wr_acc && paddr == OFS_CLEAR)
      status_next = (status_reg & ~pwdata[EV_W-1:0]) | ev;
    if (wr_acc && paddr == OFS_ENABLE)
      enable_next = pwdata[EV_W-1:0];
    if (wr_acc && paddr == OFS_NODE)
      node_next = pwdata[6:0];
    if (psel && !penable)
    begin
      unique case (paddr)
        OFS_STATUS: prdata_next = {27'h0, status_reg};
        OFS_ENABLE: prdata_next = {27'h0, enable_reg};
        OFS_NODE: prdata_next = {25'h0, node_reg};
        OFS_COMM: prdata_next = {8'h0, etimer_reg, ttype_reg};
        OFS_LIM_LO: prdata_next = lo_reg;
        OFS_LIM_HI: prdata_next = hi_reg;
        OFS_ARMED: prdata_next = {31'h0, armed_reg};
        default: prdata_next = 32'h0;
      endcase
    end
  end
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      status_reg <= '0;
      enable_reg <= '0;
      node_reg <= NODE_RST;
      prdata_reg <= 32'h0;
    end
    else
    begin
      status_reg <= status_next;
      enable_reg <= enable_next;
      node_reg <= node_next;
      prdata_reg <= prdata_next;
    end
  end

  assign prdata = prdata_reg;
  assign irq = |(status_reg & enable_reg);

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_timer_mode: assert property (tpdo_send
    && $past(ttype_reg) == TT_TIMER |-> $past(ms_tick))
    else $error("timer send off tick");
  a_timer_period: assert property (fire_tmr
    |-> ms_cnt_reg == etimer_reg - 16'h1) else $error("timer period wrong");
  a_timer_zero: assert property (etimer_reg == 16'h0
    |-> !fire_tmr) else $error("zero timer fired");
  a_sync_range: assert property (fire_sync
    |-> ttype_reg >= 8'h01 && ttype_reg <= 8'hf0) else $error("bad sync");
  a_ttype_store: assert property (wr_tt
    |=> ttype_reg == $past(wdat[7:0])) else $error("type not stored");
  a_event_only: assert property (ttype_reg == TT_EVENT
    && !fire_evt |=> !tpdo_send) else $error("event mode leaked");
  a_limit_store: assert property (wr_lo
    |=> lo_reg == $past(wdat)) else $error("lower limit not stored");
  a_event_send: assert property (fire_evt
    |=> tpdo_send && !armed_reg) else $error("event send missing");
  a_rearm_band: assert property (!armed_reg ##1 armed_reg
    |-> $past(in_band)) else $error("rearm outside band");
  a_ack_frame: assert property (wr_ok
    |=> tx_valid && tx_data[7:0] == 8'h60 && tx_data[63:32] == 32'h0)
    else $error("ack frame wrong");
  a_save_pulse: assert property (nvm_save
    |-> $past(wr_save) && tx_valid) else $error("save without request");
  a_restore_val: assert property (wr_load && !wr_tt
    |=> ttype_reg == TT_TIMER && nvm_restore) else $error("restore failed");
  a_sync_wrap: assert property (fire_sync
    |=> sync_cnt_reg == 8'h0 && tpdo_send) else $error("sync count stuck");

  c_timer: cover property (fire_tmr ##1 tpdo_send);
  c_sync: cover property (fire_sync && ttype_reg > 8'h1);
  c_event: cover property (fire_evt ##[1:50] armed_reg);
  c_save: cover property (wr_save ##1 tx_valid);

endmodule : tpt_trigger

// File: common/tpt_pkg.sv
package tpt_pkg;
  // apb map
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CLEAR = 8'h04;
  localparam logic [7:0] OFS_ENABLE = 8'h08;
  localparam logic [7:0] OFS_NODE = 8'h0c;
  localparam logic [7:0] OFS_COMM = 8'h10;
  localparam logic [7:0] OFS_LIM_LO = 8'h14;
  localparam logic [7:0] OFS_LIM_HI = 8'h18;
  localparam logic [7:0] OFS_ARMED = 8'h1c;
  // status bits
  localparam int EV_TPDO = 0;
  localparam int EV_ACK = 1;
  localparam int EV_SAVE = 2;
  localparam int EV_RESTORE = 3;
  localparam int EV_LIMIT = 4;
  localparam int EV_W = 5;
  // reset and factory values
  localparam logic [6:0] NODE_RST = 7'h01;
  localparam logic [7:0] TTYPE_FACT = 8'hfe;
  localparam logic [15:0] ETIMER_FACT = 16'h0000;
  localparam logic [31:0] LIM_LO_FACT = 32'h00000000;
  localparam logic [31:0] LIM_HI_FACT = 32'h00000000;
  // transmission types
  localparam logic [7:0] TT_SYNC_MIN = 8'h01;
  localparam logic [7:0] TT_SYNC_MAX = 8'hf0;
  localparam logic [7:0] TT_TIMER = 8'hfe;
  localparam logic [7:0] TT_EVENT = 8'hff;
  // sdo framing
  localparam logic [10:0] SDO_RX_BASE = 11'h600;
  localparam logic [10:0] SDO_TX_BASE = 11'h580;
  localparam logic [3:0] SDO_DLC = 4'h8;
  localparam logic [7:0] CMD_DL4 = 8'h22;
  localparam logic [7:0] CMD_ACK = 8'h60;
  // object dictionary
  localparam logic [15:0] IDX_TPDO1 = 16'h1800;
  localparam logic [7:0] SUB_TTYPE = 8'h02;
  localparam logic [7:0] SUB_ETIMER = 8'h05;
  localparam logic [15:0] IDX_LIM_LO = 16'h6134;
  localparam logic [15:0] IDX_LIM_HI = 16'h6135;
  localparam logic [15:0] IDX_SAVE = 16'h1010;
  localparam logic [15:0] IDX_LOAD = 16'h1011;
  localparam logic [7:0] SUB_ONE = 8'h01;
  // little-endian words of the ascii signatures
  localparam logic [31:0] SIG_SAVE = 32'h65766173;
  localparam logic [31:0] SIG_LOAD = 32'h64616f6c;
  // hysteresis: 1 percent as a 2^-30 fraction
  localparam logic [23:0] PCT_MUL = 24'ha3d70a;
endpackage : tpt_pkg

// File: bench/tpt_master.sv
`timescale 1ns/1ps
module tpt_master
  import tpt_pkg::*;
(
  input wire logic core_clk,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [10:0] rx_id,
  output logic [3:0] rx_dlc,
  output logic [63:0] rx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [10:0] tx_id,
  input wire logic [63:0] tx_data,
  output logic sync_pulse
);
  initial
  begin
    rx_valid = 1'b0;
    rx_id = 11'h7ff;
    rx_dlc = 4'hf;
    rx_data = 64'ha5a5a5a5a5a5a5a5;
    tx_ready = 1'b0;
    sync_pulse = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // expedited download, then wait a bounded time for the answer
  task automatic sdo(input logic [10:0] id, input logic [15:0] idx,
    input logic [7:0] sub, input logic [31:0] val, output logic got,
    output logic [10:0] aid, output logic [63:0] adat);
    int n;
    got = 1'b0;
    aid = 11'h000;
    adat = 64'h0;
    @(posedge core_clk);
    rx_valid <= 1'b1;
    rx_id <= id;
    rx_dlc <= SDO_DLC;
    rx_data <= {val, sub, idx[15:8], idx[7:0], 8'h22};
    do
      @(posedge core_clk);
    while (rx_ready !== 1'b1);
    // released id and data lines never keep the old frame; dlc stays at SDO_DLC
    rx_valid <= 1'b0;
    rx_id <= ~rx_id;
    rx_data <= ~rx_data;
    for (n = 0; n < 8 && got !== 1'b1; n++)
    begin
      @(posedge core_clk);
      if (tx_valid === 1'b1)
      begin
        got = 1'b1;
        aid = tx_id;
        adat = tx_data;
        tx_ready <= 1'b1;
        @(posedge core_clk);
        tx_ready <= 1'b0;
      end
    end
  endtask : sdo

  ////////////////////////////////////////////////////////////////////////////
  task automatic syncs(input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      sync_pulse <= 1'b1;
      @(posedge core_clk);
      sync_pulse <= 1'b0;
    end
  endtask : syncs
endmodule : tpt_master

// File: bench/testbench.sv
`timescale 1ns/1ps
module testbench
  import tpt_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, pv_value = 32'h0;
  logic pready, pslverr, rx_valid, rx_ready, tx_valid, tx_ready, irq;
  logic [10:0] rx_id, tx_id;
  logic [3:0] rx_dlc, tx_dlc;
  logic [63:0] rx_data, tx_data;
  logic sync_pulse, ms_tick = 1'b0, pv_valid = 1'b0;
  logic tpdo_send, nvm_save, nvm_restore;
  int fails = 0, checks_done = 0, n_send = 0, n_save = 0, n_rest = 0;

  always #4 core_clk = ~core_clk;

  tpt_trigger tpt_trigger_inst (.core_clk(core_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_id(rx_id),
    .rx_dlc(rx_dlc), .rx_data(rx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_id(tx_id), .tx_dlc(tx_dlc), .tx_data(tx_data),
    .sync_pulse(sync_pulse), .ms_tick(ms_tick), .pv_valid(pv_valid),
    .pv_value(pv_value), .tpdo_send(tpdo_send), .nvm_save(nvm_save),
    .nvm_restore(nvm_restore), .irq(irq));

  tpt_master master_inst (.core_clk(core_clk), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_id(rx_id), .rx_dlc(rx_dlc), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_id(tx_id),
    .tx_data(tx_data), .sync_pulse(sync_pulse));

  always @(posedge core_clk)
  begin
    if (tpdo_send === 1'b1) n_send++;
    if (nvm_save === 1'b1) n_save++;
    if (nvm_restore === 1'b1) n_rest++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask : idle

  task automatic apb(input logic wr_en, input logic [7:0] addr,
    input logic [31:0] wd, output logic [31:0] rd, output logic err);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= addr;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do
      @(posedge core_clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic reg_is(input logic [7:0] addr, input logic [31:0] exp);
    logic [31:0] d;
    logic e;
    apb(1'b0, addr, 32'h0, d, e);
    check(d, exp);
  endtask : reg_is

  task automatic reg_wr(input logic [7:0] addr, input logic [31:0] v);
    logic [31:0] d;
    logic e;
    apb(1'b1, addr, v, d, e);
  endtask : reg_wr

  task automatic wr(input logic [15:0] idx, input logic [7:0] sub,
    input logic [31:0] val, input logic ack);
    logic got;
    logic [10:0] aid;
    logic [63:0] adat;
    master_inst.sdo(SDO_RX_BASE + 11'h001, idx, sub, val, got, aid, adat);
    check(got, ack);
    if (got === 1'b1)
    begin
      check(aid, SDO_TX_BASE + 11'h001);
      check(adat, {32'h0, sub, idx, 8'h60});
      check(tx_dlc, SDO_DLC);
    end
  endtask : wr

  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      ms_tick <= 1'b1;
      @(posedge core_clk);
      ms_tick <= 1'b0;
    end
    idle(3);
  endtask : ticks

  task automatic pv(input logic [31:0] v, input int exp_sends);
    int b;
    b = n_send;
    @(posedge core_clk);
    pv_valid <= 1'b1;
    pv_value <= v;
    @(posedge core_clk);
    pv_valid <= 1'b0;
    idle(4);
    check(n_send - b, exp_sends);
  endtask : pv

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_map;
    logic [31:0] d;
    logic e;
    reg_is(OFS_COMM, 32'h000000fe);
    reg_is(OFS_NODE, 32'h00000001);
    apb(1'b0, 8'h40, 32'h0, d, e);
    check({e, d}, 33'h100000000);
  endtask : t_reset_map

  task automatic t_timer;
    int b;
    wr(IDX_TPDO1, 8'h05, 32'h00000003, 1'b1);
    reg_is(OFS_COMM, 32'h000003fe);
    b = n_send;
    ticks(2);
    check(n_send - b, 0);
    ticks(1);
    check(n_send - b, 1);
    ticks(3);
    check(n_send - b, 2);
    wr(IDX_TPDO1, 8'h05, 32'h0, 1'b1);
    ticks(6);
    check(n_send - b, 2);
  endtask : t_timer

  task automatic t_sync;
    int b;
    wr(IDX_TPDO1, 8'h02, 32'h00000003, 1'b1);
    reg_wr(OFS_ENABLE, 32'h00000001);
    reg_wr(OFS_CLEAR, 32'h0000001f);
    b = n_send;
    master_inst.syncs(2);
    idle(3);
    check({n_send - b, irq}, 0);
    master_inst.syncs(1);
    idle(3);
    check({n_send - b, irq}, 3);
    reg_is(OFS_STATUS, 32'h00000001);
    master_inst.syncs(3);
    idle(3);
    check(n_send - b, 2);
    reg_wr(OFS_CLEAR, 32'h00000001);
    idle(2);
    check(irq, 0);
  endtask : t_sync

  task automatic t_event;
    int b;
    wr(IDX_TPDO1, 8'h02, 32'h000000ff, 1'b1);
    wr(IDX_TPDO1, 8'h05, 32'h0, 1'b1);
    wr(IDX_LIM_LO, 8'h01, 32'h3f800000, 1'b1);
    wr(IDX_LIM_HI, 8'h01, 32'h40000000, 1'b1);
    reg_is(OFS_LIM_HI, 32'h40000000);
    reg_is(OFS_LIM_LO, 32'h3f800000);
    pv(32'h3fc00000, 0);
    reg_is(OFS_ARMED, 32'h00000001);
    pv(32'h40200000, 1);
    reg_is(OFS_ARMED, 32'h00000000);
    pv(32'h40400000, 0);
    pv(32'h3ffeb852, 0);
    pv(32'h40200000, 0);
    pv(32'h3fc00000, 0);
    pv(32'h3f000000, 1);
    b = n_send;
    master_inst.syncs(4);
    ticks(4);
    check(n_send - b, 0);
  endtask : t_event

  task automatic t_store;
    logic got;
    logic [10:0] aid;
    logic [63:0] adat;
    wr(IDX_SAVE, 8'h01, 32'h65766173, 1'b1);
    wr(IDX_SAVE, 8'h01, 32'h65766174, 1'b0);
    check(n_save, 1);
    wr(IDX_LOAD, 8'h01, 32'h64616f6c, 1'b1);
    check({n_rest, n_save}, {32'd1, 32'd1});
    reg_is(OFS_COMM, 32'h000000fe);
    reg_is(OFS_LIM_HI, 32'h0);
    master_inst.sdo(11'h602, IDX_TPDO1, 8'h02, 32'h1, got, aid, adat);
    check(got, 1'b0);
  endtask : t_store

  initial
  begin
    idle(10);
    rst_n <= 1'b1;
    t_reset_map();
    t_timer();
    t_sync();
    t_event();
    t_store();
    idle(5);
    results();
  end

  initial
  begin
    #(8 * 20000);
    fails++;
    results();
  end
endmodule : testbench
